// ---- core/ctrc_ctrl.sv ----
// cache tag ram controller: sequences lookup, tag write, tag read and flash clear on the device pins
`timescale 1ns/1ps
module ctrc_ctrl (
    input  wire logic                        mclk,
    input  wire logic                        resetn,
    input  wire logic                        req_valid,
    output logic                             req_ready,
    input  wire ctrc_pkg::ctrc_req_s         req,
    output logic                             resp_valid,
    output ctrc_pkg::ctrc_resp_s             resp,
    output ctrc_pkg::ctrc_pins_s             pins,
    input  wire logic [ctrc_pkg::TAG_W-1:0]  dq_i,
    input  wire logic                        match_i
);
    typedef enum logic [3:0] {
        ST_START, ST_IDLE, ST_CLEAR, ST_REC, ST_SETUP,
        ST_WRITE, ST_READ, ST_CMP, ST_DESEL
    } ctrc_state_e;

    ctrc_state_e                    state_q, state_d;
    logic [ctrc_pkg::CNT_W-1:0]     cnt_q, cnt_d;
    ctrc_pkg::ctrc_op_e             op_q;
    logic [ctrc_pkg::TAG_W-1:0]     tag_q;
    logic [ctrc_pkg::TAG_W:0]       samp;
    logic                           last;

    function automatic logic [ctrc_pkg::CNT_W-1:0] cyc(input int n);
        cyc = ctrc_pkg::CNT_W'(n - 1);
    endfunction

    // match and data pins come from the device, not our clock domain
    ctrc_sync #(.W(ctrc_pkg::TAG_W + 1)) u_sync (
        .mclk   (mclk),
        .resetn (resetn),
        .d      ({match_i, dq_i}),
        .q      (samp)
    );

    assign req_ready = (state_q == ST_IDLE);
    assign last      = (cnt_q == '0);

    always_comb begin
        state_d = state_q;
        cnt_d   = last ? cnt_q : cnt_q - 1'b1;
        unique case (state_q)
            ST_START: begin
                state_d = ST_CLEAR;
                cnt_d   = cyc(ctrc_pkg::RSPW_CYC);
            end
            ST_IDLE: begin
                if (req_valid) begin
                    state_d = (req.op == ctrc_pkg::CTRC_OP_CLEAR) ? ST_CLEAR : ST_SETUP;
                    cnt_d   = (req.op == ctrc_pkg::CTRC_OP_CLEAR) ? cyc(ctrc_pkg::RSPW_CYC) : '0;
                end
            end
            ST_CLEAR: begin
                if (last) begin
                    state_d = ST_REC;
                    cnt_d   = cyc(ctrc_pkg::RSRC_CYC);
                end
            end
            ST_REC: begin
                if (last) begin
                    state_d = ST_IDLE;
                end
            end
            ST_SETUP: begin
                unique case (op_q)
                    ctrc_pkg::CTRC_OP_WRITE: begin
                        state_d = ST_WRITE;
                        cnt_d   = cyc(ctrc_pkg::WP_CYC);
                    end
                    ctrc_pkg::CTRC_OP_READ: begin
                        state_d = ST_READ;
                        cnt_d   = cyc(ctrc_pkg::RD_CYC);
                    end
                    default: begin
                        state_d = ST_CMP;
                        cnt_d   = cyc(ctrc_pkg::CMP_CYC);
                    end
                endcase
            end
            ST_WRITE, ST_READ, ST_CMP: begin
                if (last) begin
                    state_d = ST_DESEL;
                    cnt_d   = cyc(ctrc_pkg::HZ_CYC);
                end
            end
            ST_DESEL: begin
                if (last) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_START;
            cnt_q   <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // tag latched only in idle, while the device is deselected
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            op_q      <= ctrc_pkg::CTRC_OP_LOOKUP;
            tag_q     <= '0;
        end else if (req_valid && req_ready) begin
            op_q      <= req.op;
            tag_q     <= req.caddr[ctrc_pkg::TAG_LSB +: ctrc_pkg::TAG_W];
        end
    end

    // pins registered from the next state so strobes never glitch
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pins.addr    <= '0;
            pins.cs_n    <= 1'b1;
            pins.we_n    <= 1'b1;
            pins.oe_n    <= 1'b1;
            pins.clr_n   <= 1'b1;
            pins.dq_o    <= '0;
            pins.dq_oe_n <= 1'b1;
        end else begin
            if (req_valid && req_ready) begin
                // wider tags: a second controller on the same index, results ANDed by the user
                pins.addr <= req.caddr[ctrc_pkg::IDX_LSB +: ctrc_pkg::IDX_W];
            end
            pins.cs_n    <= !(state_d inside {ST_WRITE, ST_READ, ST_CMP});
            pins.we_n    <= (state_d != ST_WRITE);
            pins.oe_n    <= (state_d != ST_READ);
            pins.clr_n   <= (state_d != ST_CLEAR);
            pins.dq_o    <= tag_q;
            pins.dq_oe_n <= !((state_d == ST_SETUP && op_q != ctrc_pkg::CTRC_OP_READ) ||
                               state_d == ST_WRITE || state_d == ST_CMP);
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            resp_valid <= 1'b0;
            resp       <= '0;
        end else begin
            resp_valid <= last && (state_q inside {ST_WRITE, ST_READ, ST_CMP} ||
                                   (state_q == ST_REC && op_q == ctrc_pkg::CTRC_OP_CLEAR));
            if (last && state_q == ST_READ) begin
                resp.rdata <= samp[ctrc_pkg::TAG_W-1:0];
            end
            if (last && state_q == ST_CMP) begin
                // released net reads high through the pull-up, shared by wired devices
                resp.hit <= samp[ctrc_pkg::TAG_W];
            end
        end
    end

    // clear requests also reach op_q so their completion is reported
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    // clear pulse is too long to unroll as a repeat, so its low cycles are counted
    logic [ctrc_pkg::CNT_W-1:0]     clr_low_q;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            clr_low_q <= '0;
        end else if (pins.clr_n) begin
            clr_low_q <= '0;
        end else if (clr_low_q != '1) begin
            clr_low_q <= clr_low_q + 1'b1;
        end
    end

    sequence s_clear_width;
        clr_low_q == ctrc_pkg::CNT_W'(ctrc_pkg::RSPW_CYC);
    endsequence

    sequence s_recover;
        (pins.clr_n && pins.we_n) [*6];
    endsequence

    sequence s_write_low;
        (!pins.we_n && !pins.cs_n) [*3];
    endsequence

    sequence s_select_hold;
        (!pins.cs_n && $stable(pins.addr)) [*7];
    endsequence

    a_addr_quiet: assert property ($changed(pins.addr) |-> pins.cs_n && pins.we_n && $past(pins.cs_n))
        else $error("address moved while device selected");
    a_clear_pulse: assert property ($rose(pins.clr_n) |-> s_clear_width ##0 s_recover)
        else $error("clear pulse or recovery too short");
    a_clear_we_high: assert property (!pins.clr_n |-> pins.we_n && pins.cs_n)
        else $error("write strobe active during clear");
    a_power_clear: assert property ($rose(resetn) |-> ##[1:3] !pins.clr_n)
        else $error("no clear after reset release");
    a_tag_drive: assert property (!pins.cs_n && pins.we_n && pins.oe_n |-> !pins.dq_oe_n &&
                                  pins.dq_o == tag_q)
        else $error("compare without tag on data pins");
    a_no_fight: assert property (!pins.oe_n |-> pins.dq_oe_n)
        else $error("data pins driven during device read");
    a_hit_sample: assert property (state_q == ST_CMP && last |=> resp_valid &&
                                   resp.hit == $past(samp[ctrc_pkg::TAG_W]))
        else $error("hit not taken from shared match net");
    a_write_pulse: assert property ($fell(pins.we_n) |-> s_write_low ##1 pins.we_n)
        else $error("write pulse width wrong");
    a_addr_stable: assert property (!pins.cs_n |-> $stable(pins.addr))
        else $error("address moved during a selected cycle");
    a_clear_idle: assert property (!pins.clr_n |-> !req_ready)
        else $error("request accepted while clear is active");
    a_index_split: assert property (req_valid && req_ready |=>
                                    pins.addr == $past(req.caddr[ctrc_pkg::IDX_LSB +: ctrc_pkg::IDX_W]) &&
                                    tag_q == $past(req.caddr[ctrc_pkg::TAG_LSB +: ctrc_pkg::TAG_W]))
        else $error("cache address split wrong");
    a_cmp_window: assert property ($fell(pins.cs_n) && pins.we_n && pins.oe_n |-> s_select_hold ##1 pins.cs_n)
        else $error("compare window wrong");
endmodule

// ---- core/ctrc_pkg.sv ----
// constants, types and pin bundles for the cache tag ram controller
package ctrc_pkg;
    localparam int CLK_PERIOD_NS = 5;
    localparam int T_RSPW_NS     = 45;
    localparam int T_RSRC_NS     = 30;
    localparam int T_WP_NS       = 15;
    localparam int T_AA_NS       = 20;
    localparam int T_ADM_NS      = 20;
    localparam int T_OHZ_NS      = 8;
    localparam int SYNC_STAGES   = 2;

    localparam int RSPW_CYC = (T_RSPW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RSRC_CYC = (T_RSRC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WP_CYC   = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HZ_CYC   = (T_OHZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // result must cross both sampling flops before it is taken
    localparam int RD_CYC   = (T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES + 1;
    localparam int CMP_CYC  = (T_ADM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES + 1;

    localparam int CNT_W    = 4;
    localparam int IDX_W    = 13;
    localparam int TAG_W    = 8;
    localparam int CADDR_W  = IDX_W + TAG_W;
    localparam int IDX_LSB  = 0;
    localparam int TAG_LSB  = IDX_W;

    typedef enum logic [1:0] {
        CTRC_OP_LOOKUP,
        CTRC_OP_WRITE,
        CTRC_OP_READ,
        CTRC_OP_CLEAR
    } ctrc_op_e;

    typedef struct packed {
        ctrc_op_e             op;
        logic [CADDR_W-1:0]   caddr;
    } ctrc_req_s;

    typedef struct packed {
        logic                 hit;
        logic [TAG_W-1:0]     rdata;
    } ctrc_resp_s;

    typedef struct packed {
        logic [IDX_W-1:0]     addr;
        logic                 cs_n;
        logic                 we_n;
        logic                 oe_n;
        logic                 clr_n;
        logic [TAG_W-1:0]     dq_o;
        logic                 dq_oe_n;
    } ctrc_pins_s;
endpackage

// ---- core/ctrc_sync.sv ----
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ctrc_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

// ---- verif/ctrc_dev_model.sv ----
// behavioural model of the cache tag ram device seen at the controller pins
`timescale 1ns/1ps
module ctrc_dev_model (
    input  wire logic [ctrc_pkg::IDX_W-1:0] addr,
    input  wire logic                       cs_n,
    input  wire logic                       we_n,
    input  wire logic                       oe_n,
    input  wire logic                       clr_n,
    input  wire logic [ctrc_pkg::TAG_W-1:0] dq,
    output logic      [ctrc_pkg::TAG_W-1:0] dq_out,
    output logic                            dq_drv,
    output logic                            match_low
);
    logic [ctrc_pkg::TAG_W-1:0] mem [0:8191];
    // power-up contents are not zero, so only a real clear passes
    initial begin
        for (int i = 0; i < 8192; i++) begin
            mem[i] = 8'h5A;
        end
    end
    always @(clr_n, cs_n, we_n, addr, dq) begin
        if (!clr_n) begin
            for (int i = 0; i < 8192; i++) begin
                mem[i] = 8'h00;
            end
        end else if (!cs_n && !we_n) begin
            mem[addr] = dq;
        end
    end
    assign dq_out    = mem[addr];
    assign dq_drv    = clr_n && !cs_n && we_n && !oe_n;
    assign match_low = clr_n && !cs_n && we_n && oe_n && (dq !== mem[addr]);
endmodule

// ---- verif/cache_tag_ram_comparator_test.sv ----
// self-checking bench: controller against the device model
`timescale 1ns/1ps
module cache_tag_ram_comparator_test;
    logic                 mclk;
    logic                 resetn;
    logic                 req_valid;
    ctrc_pkg::ctrc_req_s  req;
    logic                 req_ready;
    logic                 resp_valid;
    ctrc_pkg::ctrc_resp_s resp;
    ctrc_pkg::ctrc_pins_s pins;
    logic [7:0]           dq_out;
    logic                 dq_drv;
    logic                 match_low;
    logic [7:0]           dq_last;
    logic [7:0]           dq_bus;
    int                   err_total;
    int                   comparisons;
    int                   n;
    // released data lines flip every cycle so stale values never pass
    assign dq_bus = !pins.dq_oe_n ? pins.dq_o : (dq_drv ? dq_out : ~dq_last);
    always @(posedge mclk) dq_last <= dq_bus;
    ctrc_ctrl DUT (.mclk(mclk), .resetn(resetn), .req_valid(req_valid), .req_ready(req_ready), .req(req),
        .resp_valid(resp_valid), .resp(resp), .pins(pins), .dq_i(dq_bus), .match_i(match_low ? 1'b0 : 1'b1));
    ctrc_dev_model DEV (.addr(pins.addr), .cs_n(pins.cs_n), .we_n(pins.we_n), .oe_n(pins.oe_n),
        .clr_n(pins.clr_n), .dq(dq_bus), .dq_out(dq_out), .dq_drv(dq_drv), .match_low(match_low));
    task end_sim;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk1(input string nm, input logic e, input logic s);
        comparisons++;
        if (s !== e) begin
            $display("BAD %s exp %b seen %b", nm, e, s);
            err_total++;
        end
    endtask
    task chk8(input string nm, input logic [7:0] e, input logic [7:0] s);
        comparisons++;
        if (s !== e) begin
            $display("BAD %s exp %h seen %h", nm, e, s);
            err_total++;
        end
    endtask
    task chkn(input string nm, input int e, input int s);
        comparisons++;
        if (s != e) begin
            $display("BAD %s exp %0d seen %0d", nm, e, s);
            err_total++;
        end
    endtask
    // waits for ready, hands over one request, counts edges to resp_valid
    task do_op(input ctrc_pkg::ctrc_op_e op, input logic [20:0] ca);
        int k;
        @(posedge mclk);
        req <= '{op: op, caddr: ca};
        req_valid <= 1'b1;
        k = 0;
        @(negedge mclk);
        while (req_ready !== 1'b1 && k < 100) begin
            @(negedge mclk);
            k++;
        end
        if (k == 100) begin
            err_total++;
            end_sim();
        end
        @(posedge mclk);
        req_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (resp_valid !== 1'b1 && n < 100);
        if (n == 100) begin
            err_total++;
            end_sim();
        end
    endtask
    task t_power;
        do_op(ctrc_pkg::CTRC_OP_READ, {8'h00, 13'h0005});
        chk8("poweron rdata", 8'h00, resp.rdata);
        chkn("read latency", ctrc_pkg::RD_CYC + 1, n);
        do_op(ctrc_pkg::CTRC_OP_LOOKUP, {8'h00, 13'h1FFF});
        chk1("poweron hit", 1'b1, resp.hit);
    endtask
    task t_write_read;
        do_op(ctrc_pkg::CTRC_OP_WRITE, {8'hA5, 13'h0123});
        chkn("write latency", ctrc_pkg::WP_CYC + 1, n);
        chk8("mem 0123", 8'hA5, DEV.mem[13'h0123]);
        chk8("mem 0124", 8'h00, DEV.mem[13'h0124]);
        do_op(ctrc_pkg::CTRC_OP_READ, {8'h00, 13'h0123});
        chk8("read 0123", 8'hA5, resp.rdata);
    endtask
    task t_lookup;
        logic [7:0] tags [4];
        tags = '{8'hA5, 8'hA4, 8'h25, 8'h00};
        for (int i = 0; i < 4; i++) begin
            do_op(ctrc_pkg::CTRC_OP_LOOKUP, {tags[i], 13'h0123});
            chk1("lookup hit", tags[i] == 8'hA5, resp.hit);
            chkn("lookup latency", ctrc_pkg::CMP_CYC + 1, n);
            chk1("deselect", 1'b1, pins.cs_n);
        end
    endtask
    task t_back;
        do_op(ctrc_pkg::CTRC_OP_WRITE, {8'h3C, 13'h1FFF});
        do_op(ctrc_pkg::CTRC_OP_WRITE, {8'hC3, 13'h0000});
        do_op(ctrc_pkg::CTRC_OP_READ, {8'h00, 13'h1FFF});
        chk8("read 1FFF", 8'h3C, resp.rdata);
        do_op(ctrc_pkg::CTRC_OP_READ, {8'h00, 13'h0000});
        chk8("read 0000", 8'hC3, resp.rdata);
    endtask
    task t_clear;
        do_op(ctrc_pkg::CTRC_OP_CLEAR, 21'h00_0000);
        chkn("clear latency", ctrc_pkg::RSPW_CYC + ctrc_pkg::RSRC_CYC, n);
        do_op(ctrc_pkg::CTRC_OP_LOOKUP, {8'hA5, 13'h0123});
        chk1("hit after clear", 1'b0, resp.hit);
        do_op(ctrc_pkg::CTRC_OP_READ, {8'h00, 13'h1FFF});
        chk8("read after clear", 8'h00, resp.rdata);
    endtask
    // reset in mid-run must clear the device again before the next read
    task t_reset;
        do_op(ctrc_pkg::CTRC_OP_WRITE, {8'h77, 13'h0042});
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        do_op(ctrc_pkg::CTRC_OP_READ, {8'h00, 13'h0042});
        chk8("read after reset", 8'h00, resp.rdata);
    endtask
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    initial begin
        resetn = 1'b0;
        req_valid = 1'b0;
        req = '0;
        dq_last = 8'h00;
        err_total = 0;
        comparisons = 0;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        t_power();
        t_write_read();
        t_lookup();
        t_back();
        t_clear();
        t_reset();
        end_sim();
    end
endmodule
